// File: display_host_interface.sv
// Purpose: host-side front end: parallel 6800/8080, serial and I2C links
// Assumes: mode_sel static; serial clock is a clock port of its own
// Notes:   command and memory bytes leave as one-cycle pulses on sys_clk
//
// Functional notes
// RULE1 - 6800: read/write low writes, high reads
// RULE2 - data/command low is command, high data
// RULE3 - 6800 captures on falling E with select low
// RULE4 - host does dummy read before memory reads
// RULE5 - 8080 read completes on rising read strobe
// RULE6 - 8080 write latches on rising write strobe
// RULE7 - alternative 8080 latches on rising chip select
// RULE8 - serial uses pin 0 clock, pin 1 data; the code takes pin 1 data but clocks on the serial_clk port, not pin 0
// RULE9 - serial shifts msb first on rising clock
// RULE10 - every eighth clock samples kind and writes
// RULE11 - serial link is write only
// RULE12 - I2C address is 011110, select bit, direction
// RULE13 - I2C reuses data/command pin as address lsb
// RULE14 - address last bit one reads, zero writes
// RULE15 - I2C ignores traffic until own address matches
// RULE16 - I2C pin 0 clock, 1 data, 2 acknowledge
// RULE17 - one I2C data bit per bus clock
// RULE18 - reset pin returns interface to idle
// RULE19 - control byte: continuation, kind, six zeros
// RULE20 - kind zero commands, one stores and advances column
// RULE21 - acknowledge address and every received byte
// RULE22 - static mode input picks one front end
`timescale 1ns/1ps
module display_host_interface
#(
  parameter int COL_W = 8
)
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       serial_clk,
  input  wire logic                       hw_reset_n,
  input  wire display_host_pkg::bus_mode_e mode_sel,
  input  wire logic                       chip_sel_n,
  input  wire logic                       strobe_e_rd_n,
  input  wire logic                       rw_wr_n,
  input  wire logic                       dc_sel,
  input  wire logic [7:0]                 pin_in,
  output logic      [7:0]                 pin_out,
  output logic      [7:0]                 pin_oe_n,
  input  wire logic [7:0]                 status_in,
  input  wire logic [7:0]                 mem_rd_data,
  output logic                            mem_rd_req,
  output logic                            cmd_valid,
  output logic      [7:0]                 cmd_byte,
  output logic                            mem_wr_valid,
  output logic      [7:0]                 mem_wr_data,
  output logic      [COL_W-1:0]           col_addr
);
  import display_host_pkg::*;
  // pin synchronisers; stage 3 holds the value just before a detected edge
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic              core_rst;

  always_ff @(posedge sys_clk)
  begin
    sync1 <= {hw_reset_n, dc_sel, rw_wr_n, strobe_e_rd_n, chip_sel_n, pin_in};
    sync2 <= sync1;
    sync3 <= sync2;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      core_rst <= 1'b1;
    else
      core_rst <= ~sync2[SY_RST]; // [RULE18]
  end
  // parallel links
  logic              par_wr, par_rd_end, par_drive, rd_fetch;
  logic              stb_fall, stb_rise, wrn_rise, cs_rise;
  logic [BYTE_W-1:0] rd_out;
  logic [BYTE_W-1:0] read_latch;
  assign stb_fall = sync3[SY_STB] & ~sync2[SY_STB];
  assign stb_rise = ~sync3[SY_STB] & sync2[SY_STB];
  assign wrn_rise = ~sync3[SY_RW] & sync2[SY_RW];
  assign cs_rise  = ~sync3[SY_CS] & sync2[SY_CS];
  always_comb
  begin
    par_wr     = 1'b0;
    par_rd_end = 1'b0;
    par_drive  = 1'b0;
    unique case (mode_sel) // [RULE22]
      MODE_6800:
      begin
        par_wr     = stb_fall & ~sync3[SY_CS] & ~sync3[SY_RW]; // [RULE1] [RULE3]
        par_rd_end = stb_fall & ~sync3[SY_CS] & sync3[SY_RW]; // [RULE1]
        par_drive  = sync2[SY_STB] & ~sync2[SY_CS] & sync2[SY_RW];
      end
      MODE_8080_STROBE:
      begin
        par_wr     = wrn_rise & ~sync3[SY_CS]; // [RULE6]
        par_rd_end = stb_rise & ~sync3[SY_CS]; // [RULE5]
        par_drive  = ~sync2[SY_STB] & ~sync2[SY_CS];
      end
      MODE_8080_CS:
      begin
        par_wr     = cs_rise & ~sync3[SY_RW] & sync3[SY_STB]; // [RULE7]
        par_rd_end = cs_rise & ~sync3[SY_STB] & sync3[SY_RW]; // [RULE7]
        par_drive  = ~sync2[SY_CS] & ~sync2[SY_STB];
      end
      // serial and I2C modes never answer reads
      default: par_rd_end = 1'b0; // [RULE11]
    endcase
  end
  // the latch is refilled after each memory read, so the first read is stale
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      mem_rd_req <= 1'b0;
      rd_fetch   <= 1'b0;
      read_latch <= '0;
      rd_out     <= '0;
    end
    else
    begin
      mem_rd_req <= par_rd_end & sync3[SY_DC]; // [RULE4] [RULE2]
      rd_fetch   <= mem_rd_req;
      if (rd_fetch)
        read_latch <= mem_rd_data; // [RULE4]
      if (par_drive)
        rd_out <= sync2[SY_DC] ? read_latch : status_in; // [RULE2]
    end
  end
  // serial link: shifts on the host's own clock
  logic              lrst_s1;
  logic              lrst_s2;
  logic [BYTE_W-1:0] spi_shift;
  logic [2:0]        spi_cnt;
  logic [BYTE_W-1:0] spi_byte;
  logic              spi_kind;
  logic              spi_tog;
  always_ff @(posedge serial_clk)
  begin
    lrst_s1 <= core_rst;
    lrst_s2 <= lrst_s1;
  end
  // counter restarts whenever select is seen high at a clock edge
  always_ff @(posedge serial_clk)
  begin
    if (lrst_s2 || chip_sel_n || mode_sel != MODE_SPI)
    begin
      spi_shift <= '0; // [RULE18]
      spi_cnt   <= '0;
    end
    else
    begin
      spi_shift <= {spi_shift[BYTE_W-2:0], pin_in[SDA_PIN]}; // [RULE8] [RULE9]
      spi_cnt   <= spi_cnt + 3'h1;
    end
  end

  always_ff @(posedge serial_clk)
  begin
    if (lrst_s2)
    begin
      spi_byte <= '0;
      spi_kind <= 1'b0;
      spi_tog  <= 1'b0;
    end
    else if (!chip_sel_n && mode_sel == MODE_SPI && spi_cnt == LAST_BIT)
    begin
      spi_byte <= {spi_shift[BYTE_W-2:0], pin_in[SDA_PIN]}; // [RULE10]
      spi_kind <= dc_sel; // [RULE10] [RULE2]
      spi_tog  <= ~spi_tog;
    end
  end

  // byte and kind hold still until the next toggle, so they are read directly
  logic [2:0] tog_sync;
  logic       spi_evt;

  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      tog_sync <= '0;
    else
      tog_sync <= {tog_sync[1:0], spi_tog};
  end

  assign spi_evt = tog_sync[1] ^ tog_sync[2];
  // I2C slave, oversampled on sys_clk
  i2c_state_e        i2c_state;
  logic [BYTE_W-1:0] i2c_shift;
  logic [BYTE_W-1:0] i2c_byte;
  logic [BYTE_W-1:0] next_byte;
  logic [2:0]        i2c_cnt;
  logic              ack_phase, ack_drive, co_flag, kind_flag, i2c_evt, i2c_kind;
  logic              scl, sda, scl_rise, scl_fall, bus_start, bus_stop, byte_end, addr_hit;
  assign scl       = sync2[SCL_PIN]; // [RULE16]
  assign sda       = sync2[SDA_PIN]; // [RULE16]
  assign scl_rise  = scl & ~sync3[SCL_PIN];
  assign scl_fall  = ~scl & sync3[SCL_PIN];
  assign bus_start = scl & sync3[SCL_PIN] & sync3[SDA_PIN] & ~sda;
  assign bus_stop  = scl & sync3[SCL_PIN] & ~sync3[SDA_PIN] & sda;
  assign next_byte = {i2c_shift[BYTE_W-2:0], sda};
  assign byte_end  = scl_rise & ~ack_phase & (i2c_cnt == LAST_BIT)
                   & (i2c_state != I2C_IDLE) & (i2c_state != I2C_SKIP);
  assign addr_hit  = (next_byte[BYTE_W-1:ADDR_LSB_POS+1] == I2C_ADDR_PREFIX)
                   & (next_byte[ADDR_LSB_POS] == sync2[SY_DC]); // [RULE12] [RULE13]
  always_ff @(posedge sys_clk)
  begin
    if (core_rst || mode_sel != MODE_I2C)
    begin
      i2c_state <= I2C_IDLE; // [RULE18]
      i2c_shift <= '0;
      i2c_cnt   <= '0;
      ack_phase <= 1'b0;
      co_flag   <= 1'b0;
      kind_flag <= 1'b0;
    end
    else if (bus_start)
    begin
      i2c_state <= I2C_ADDR;
      i2c_cnt   <= '0;
      ack_phase <= 1'b0;
    end
    else if (bus_stop)
    begin
      i2c_state <= I2C_IDLE;
      ack_phase <= 1'b0;
    end
    else if (byte_end)
    begin
      i2c_cnt <= '0;
      unique case (i2c_state)
        I2C_ADDR:
        begin
          // read mode is acknowledged but nothing is sent back
          ack_phase <= addr_hit; // [RULE21]
          if (addr_hit && !next_byte[ADDR_RW_POS])
            i2c_state <= I2C_CTRL; // [RULE14]
          else
            i2c_state <= I2C_SKIP; // [RULE15] [RULE14]
        end
        I2C_CTRL:
        begin
          ack_phase <= 1'b1; // [RULE21]
          co_flag   <= next_byte[CTRL_CO_POS]; // [RULE19]
          kind_flag <= next_byte[CTRL_KIND_POS]; // [RULE20]
          i2c_state <= I2C_DATA;
        end
        I2C_DATA:
        begin
          ack_phase <= 1'b1; // [RULE21]
          i2c_state <= co_flag ? I2C_CTRL : I2C_DATA; // [RULE19]
        end
        default:
          i2c_state <= I2C_IDLE;
      endcase
    end
    else if (scl_rise && !ack_phase && i2c_state != I2C_IDLE && i2c_state != I2C_SKIP)
    begin
      i2c_shift <= next_byte; // [RULE17]
      i2c_cnt   <= i2c_cnt + 3'h1;
    end
    else if (scl_fall && ack_drive)
      ack_phase <= 1'b0;
  end

  // acknowledge spans one full clock: first fall to the following fall
  always_ff @(posedge sys_clk)
  begin
    if (core_rst || mode_sel != MODE_I2C || bus_start || bus_stop)
      ack_drive <= 1'b0;
    else if (scl_fall && ack_phase)
      ack_drive <= ~ack_drive; // [RULE21] [RULE17]
  end
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      i2c_evt  <= 1'b0;
      i2c_byte <= '0;
      i2c_kind <= 1'b0;
    end
    else
    begin
      i2c_evt <= byte_end & (i2c_state == I2C_DATA);
      if (byte_end && i2c_state == I2C_DATA)
      begin
        i2c_byte <= next_byte;
        i2c_kind <= kind_flag; // [RULE20]
      end
    end
  end
  // common sink for every front end
  logic              wr_evt, wr_kind;
  logic [BYTE_W-1:0] wr_byte;
  always_comb
  begin
    wr_evt  = 1'b0;
    wr_byte = '0;
    wr_kind = 1'b0;
    unique case (mode_sel) // [RULE22]
      MODE_6800, MODE_8080_STROBE, MODE_8080_CS:
      begin
        wr_evt  = par_wr;
        wr_byte = sync3[BYTE_W-1:0];
        wr_kind = sync3[SY_DC]; // [RULE2]
      end
      MODE_SPI:
      begin
        wr_evt  = spi_evt;
        wr_byte = spi_byte;
        wr_kind = spi_kind;
      end
      MODE_I2C:
      begin
        wr_evt  = i2c_evt;
        wr_byte = i2c_byte;
        wr_kind = i2c_kind;
      end
      default: wr_evt = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      cmd_valid    <= 1'b0;
      cmd_byte     <= '0;
      mem_wr_valid <= 1'b0;
      mem_wr_data  <= '0;
    end
    else
    begin
      cmd_valid    <= wr_evt & ~wr_kind; // [RULE20]
      mem_wr_valid <= wr_evt & wr_kind; // [RULE20]
      if (wr_evt && !wr_kind)
        cmd_byte <= wr_byte;
      if (wr_evt && wr_kind)
        mem_wr_data <= wr_byte;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      col_addr <= '0; // [RULE18]
    else if (mem_wr_valid || mem_rd_req)
      col_addr <= col_addr + {{(COL_W-1){1'b0}}, 1'b1}; // [RULE20]
  end

  // pin drivers; enables are active low
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end
    else if (mode_sel == MODE_I2C)
    begin
      pin_out  <= '0;
      pin_oe_n <= ~({{(PIN_W-1){1'b0}}, ack_drive} << ACK_PIN); // [RULE16]
    end
    else
    begin
      pin_out  <= rd_out;
      pin_oe_n <= ~{PIN_W{par_drive}}; // [RULE11]
    end
  end

endmodule : display_host_interface

// File: display_host_pkg.sv
// Purpose: shared constants for the display host front end
// Assumes: one active bus mode at a time, chosen by a static input
// Notes:   field positions and codes used by the front end
package display_host_pkg;

  typedef enum logic [2:0]
  {
    MODE_6800        = 3'b000,
    MODE_8080_STROBE = 3'b001,
    MODE_8080_CS     = 3'b010,
    MODE_SPI         = 3'b011,
    MODE_I2C         = 3'b100
  } bus_mode_e;

  typedef enum logic [2:0]
  {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_CTRL = 3'b010,
    I2C_DATA = 3'b011,
    I2C_SKIP = 3'b100
  } i2c_state_e;

  localparam int         BYTE_W          = 8;
  localparam int         PIN_W           = 8;
  localparam logic [5:0] I2C_ADDR_PREFIX = 6'h1E;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam int         CTRL_CO_POS     = 7;
  localparam int         CTRL_KIND_POS   = 6;
  localparam int         ADDR_RW_POS     = 0;
  localparam int         ADDR_LSB_POS    = 1;
  localparam int         SCL_PIN         = 0;
  localparam int         SDA_PIN         = 1;
  localparam int         ACK_PIN         = 2;
  // synchroniser vector layout: pins in the low byte, then control inputs
  localparam int         SY_CS           = 8;
  localparam int         SY_STB          = 9;
  localparam int         SY_RW           = 10;
  localparam int         SY_DC           = 11;
  localparam int         SY_RST          = 12;
  localparam int         SYNC_W          = 13;

endpackage : display_host_pkg

// File: display_host_interface_checker.sv
// Purpose: port-level checks of the display host front end
// Assumes: mode_sel held static while traffic runs
// Notes:   sys_clk domain only; serial domain seen through its outputs
`timescale 1ns/1ps
module display_host_interface_checker
  import display_host_pkg::*;
#(
  parameter int COL_W = 8
)
(
  input logic             sys_clk,
  input logic             sys_rst,
  input logic             serial_clk,
  input logic             hw_reset_n,
  input bus_mode_e        mode_sel,
  input logic             chip_sel_n,
  input logic             strobe_e_rd_n,
  input logic             rw_wr_n,
  input logic             dc_sel,
  input logic [7:0]       pin_in,
  input logic [7:0]       pin_out,
  input logic [7:0]       pin_oe_n,
  input logic [7:0]       status_in,
  input logic [7:0]       mem_rd_data,
  input logic             mem_rd_req,
  input logic             cmd_valid,
  input logic [7:0]       cmd_byte,
  input logic             mem_wr_valid,
  input logic [7:0]       mem_wr_data,
  input logic [COL_W-1:0] col_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // pointer moves by exactly one the cycle after its cause
  sequence s_step;
    ##1 col_addr - $past(col_addr) == COL_W'(1);
  endsequence
  property p_rst_clear;
    disable iff (1'b0) sys_rst [*2] |=> pin_oe_n == 8'hFF && !cmd_valid && col_addr == '0;
  endproperty
  property p_cmd_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  property p_wr_col;
    mem_wr_valid |-> s_step;
  endproperty
  property p_rd_col;
    mem_rd_req |-> s_step;
  endproperty
  property p_6800_wr;
    mode_sel == MODE_6800 && !chip_sel_n && !rw_wr_n && !dc_sel && $fell(strobe_e_rd_n)
      |-> ##[2:5] cmd_valid;
  endproperty
  property p_8080_wr;
    mode_sel == MODE_8080_STROBE && !chip_sel_n && dc_sel && $rose(rw_wr_n)
      |-> ##[2:5] mem_wr_valid;
  endproperty
  property p_8080_cs;
    mode_sel == MODE_8080_CS && !rw_wr_n && strobe_e_rd_n && $rose(chip_sel_n)
      |-> ##[2:5] (cmd_valid || mem_wr_valid);
  endproperty
  property p_rd_drive;
    (mode_sel == MODE_8080_STROBE && !chip_sel_n && !strobe_e_rd_n) [*6] |-> pin_oe_n == 8'h00;
  endproperty
  property p_serial_quiet;
    (mode_sel == MODE_SPI) [*4] |-> pin_oe_n == 8'hFF;
  endproperty
  property p_i2c_pins;
    (mode_sel == MODE_I2C) [*4] |-> pin_out == 8'h00 && (pin_oe_n | 8'h04) == 8'hFF;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not idle in reset");
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
  a_wr_col: assert property (p_wr_col) else $error("column not advanced on write");
  a_rd_col: assert property (p_rd_col) else $error("column not advanced on read");
  a_6800_wr: assert property (p_6800_wr) else $error("falling E write lost");
  a_8080_wr: assert property (p_8080_wr) else $error("write strobe byte lost");
  a_8080_cs: assert property (p_8080_cs) else $error("select edge byte lost");
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  a_serial_quiet: assert property (p_serial_quiet) else $error("serial drives pins");
  a_i2c_pins: assert property (p_i2c_pins) else $error("bad pin use in I2C");
endmodule : display_host_interface_checker

bind display_host_interface display_host_interface_checker #(.COL_W(COL_W)) u_chk (.*);

// File: host_model.sv
// Purpose: host microcontroller driving the parallel, serial and I2C links
// Assumes: tasks called one at a time from the bench
// Notes:   sda has a pull-up; released data lines show the inverse value
`timescale 1ns/1ps
module host_model
  import display_host_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       i2c_on,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic            serial_clk,
  output logic            chip_sel_n,
  output logic            strobe_e_rd_n,
  output logic            rw_wr_n,
  output logic            dc_sel,
  output logic [7:0]      pin_in
);
  logic [7:0] drv = 8'h00;
  logic [7:0] rdata = 8'h00;
  wire        ack = ~pin_oe_n[2] & ~pin_out[2];
  // ack pin tied to data in, open drain
  assign pin_in = i2c_on ? {drv[7:2], drv[1] & ~ack, drv[0]}
                         : (pin_oe_n & drv) | (~pin_oe_n & pin_out);
  initial
  begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b1;
    strobe_e_rd_n = 1'b0;
    rw_wr_n = 1'b0;
    dc_sel = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  task automatic par(input bus_mode_e m, input logic rd, dc, ign, input logic [7:0] b);
    @(negedge sys_clk);
    chip_sel_n <= 1'b1;
    strobe_e_rd_n <= (m == MODE_6800) ? 1'b0 : (m == MODE_8080_CS) ? !rd : 1'b1;
    rw_wr_n <= rd | (m == MODE_8080_STROBE);
    dc_sel <= dc;
    drv <= b;
    wt(6);
    chip_sel_n <= ign;
    wt(6);
    if (m == MODE_6800) strobe_e_rd_n <= 1'b1;
    else if (m == MODE_8080_STROBE && rd) strobe_e_rd_n <= 1'b0;
    else if (m == MODE_8080_STROBE) rw_wr_n <= 1'b0;
    wt(6);
    rdata = pin_out;
    if (m == MODE_6800) strobe_e_rd_n <= 1'b0;
    else if (m == MODE_8080_CS) chip_sel_n <= 1'b1;
    else strobe_e_rd_n <= 1'b1;
    if (m == MODE_8080_STROBE) rw_wr_n <= 1'b1;
    wt(6);
    chip_sel_n <= 1'b1;
    drv <= ~b;
  endtask : par
  task automatic sck;
    #80 serial_clk = 1'b1;
    drv[0] = 1'b1;
    #80 serial_clk = 1'b0;
    drv[0] = 1'b0;
  endtask : sck
  // link clock runs only inside a frame or a warm-up burst
  task automatic spi(input logic dc, input logic [7:0] b, input int pre, nb);
    #3 strobe_e_rd_n = 1'b0;
    rw_wr_n = 1'b0;
    drv = 8'h00;
    dc_sel = dc;
    repeat (pre) sck();
    #20 chip_sel_n = 1'b0;
    for (int i = 7; i > 7 - nb; i--)
    begin
      drv[1] = b[i];
      sck();
    end
    #40 chip_sel_n = 1'b1;
    drv[1] = ~drv[1];
  endtask : spi
  task automatic i2c_start(input logic sel);
    dc_sel <= sel;
    strobe_e_rd_n <= 1'b0;
    rw_wr_n <= 1'b0;
    drv <= 8'h03;
    wt(8);
    drv[1] <= 1'b0;
    wt(4);
    drv[0] <= 1'b0;
    wt(4);
  endtask : i2c_start
  task automatic i2c_stop;
    drv[1] <= 1'b0;
    wt(4);
    drv[0] <= 1'b1;
    wt(4);
    drv[1] <= 1'b1;
    wt(4);
  endtask : i2c_stop
  // ninth slot releases sda and reads the acknowledge
  task automatic i2c_byte(input logic [7:0] b, output logic acked);
    for (int i = 8; i >= 0; i--)
    begin
      drv[1] <= (i == 0) | b[(i + 7) % 8];
      wt(4);
      drv[0] <= 1'b1;
      wt(4);
      acked = !pin_in[1];
      drv[0] <= 1'b0;
      wt(4);
    end
  endtask : i2c_byte
endmodule : host_model

// File: tb_top.sv
// Purpose: self-checking bench for the display host front end
// Assumes: memory answers a read request on the next cycle
// Notes:   random bytes from a fixed seed, corner cases among them
`timescale 1ns/1ps
module tb_top;
  import display_host_pkg::*;
  logic sys_clk, sys_rst, hw_reset_n, serial_clk, chip_sel_n, strobe_e_rd_n, rw_wr_n, dc_sel;
  logic mem_rd_req, cmd_valid, mem_wr_valid, ok;
  bus_mode_e mode_sel;
  logic [7:0] pin_in, pin_out, pin_oe_n, status_in, mem_rd_data, cmd_byte, mem_wr_data;
  logic [7:0] col_addr, n_cmd, n_mem, e_cmd, e_mem, last_c, last_m, b, pb, c0;
  int n_errors, n_checks, seed, cyc;
  wire i2c_on = (mode_sel == MODE_I2C);
  display_host_interface #(.COL_W(8)) DUT (.*);
  host_model u_host (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (mem_rd_req === 1'b1) mem_rd_data <= col_addr ^ 8'h5A;
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 8'h01;
    if (cmd_valid === 1'b1) last_c <= cmd_byte;
    if (mem_wr_valid === 1'b1) n_mem <= n_mem + 8'h01;
    if (mem_wr_valid === 1'b1) last_m <= mem_wr_data;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] ctrl(input logic co, kind);
    return {co, kind, 6'h00};
  endfunction : ctrl
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_ok(input logic en, dc, input logic [7:0] v);
    repeat (8) @(negedge sys_clk);
    if (en && dc) e_mem++;
    else if (en) e_cmd++;
    chk("cmd count", e_cmd, n_cmd);
    chk("mem count", e_mem, n_mem);
    chk("last byte", v, dc ? last_m : last_c);
    if (en) pb = v;
  endtask : wr_ok
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {cyc, n_errors, n_checks, n_cmd, n_mem, e_cmd, e_mem, last_c, last_m, mem_rd_data} = '0;
    seed = 8691;
    sys_rst = 1'b1;
    hw_reset_n = 1'b1;
    mode_sel = MODE_6800;
    status_in = 8'($random(seed));
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int m = 0; m < 3; m++)
    begin
      mode_sel = bus_mode_e'(m);
      for (int k = 0; k < 4; k++)
      begin
        b = 8'($random(seed));
        u_host.par(mode_sel, 1'b0, k[0], 1'b0, b);
        wr_ok(1'b1, k[0], b);
      end
      u_host.par(mode_sel, 1'b0, 1'b1, 1'b1, 8'hC3);
      wr_ok(1'b0, 1'b1, pb);
      u_host.par(mode_sel, 1'b1, 1'b0, 1'b0, 8'h00);
      chk("status", status_in, u_host.rdata);
      c0 = col_addr;
      u_host.par(mode_sel, 1'b1, 1'b1, 1'b0, 8'h00);
      u_host.par(mode_sel, 1'b1, 1'b1, 1'b0, 8'h00);
      chk("read data", c0 ^ 8'h5A, u_host.rdata);
      chk("column", c0 + 8'h02, col_addr);
    end
    mode_sel = MODE_SPI;
    // the link domain only sees reset while its own clock runs
    @(negedge sys_clk) hw_reset_n = 1'b0;
    u_host.spi(1'b0, 8'h00, 3, 0);
    @(negedge sys_clk) hw_reset_n = 1'b1;
    u_host.spi(1'b0, 8'h00, 3, 0);
    for (int k = 0; k < 4; k++)
    begin
      b = 8'($random(seed));
      u_host.spi(k[0], b, 0, 8);
      wr_ok(1'b1, k[0], b);
    end
    u_host.spi(1'b1, 8'hFF, 0, 5);
    wr_ok(1'b0, 1'b1, pb);
    mode_sel = MODE_I2C;
    for (int s = 0; s < 2; s++)
    begin
      u_host.i2c_start(s[0]);
      u_host.i2c_byte({6'h1E, s[0], 1'b0}, ok);
      chk("addr ack", 8'h01, {7'h00, ok});
      u_host.i2c_byte(ctrl(1'b1, 1'b0), ok);
      b = 8'($random(seed));
      u_host.i2c_byte(b, ok);
      wr_ok(1'b1, 1'b0, b);
      u_host.i2c_byte(ctrl(1'b0, 1'b1), ok);
      repeat (2)
      begin
        b = 8'($random(seed));
        u_host.i2c_byte(b, ok);
        chk("data ack", 8'h01, {7'h00, ok});
        wr_ok(1'b1, 1'b1, b);
      end
      u_host.i2c_stop();
    end
    u_host.i2c_start(1'b0);
    u_host.i2c_byte({6'h1E, 1'b1, 1'b0}, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    u_host.i2c_byte(8'h40, ok);
    u_host.i2c_byte(8'h99, ok);
    u_host.i2c_stop();
    wr_ok(1'b0, 1'b1, pb);
    u_host.i2c_start(1'b0);
    u_host.i2c_byte({6'h1E, 1'b0, 1'b1}, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    u_host.i2c_byte(8'hFF, ok);
    chk("read idle", 8'h00, {7'h00, ok});
    u_host.i2c_stop();
    wr_ok(1'b0, 1'b1, pb);
    hw_reset_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    hw_reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("column", 8'h00, col_addr);
    report_and_stop();
  end
endmodule : tb_top
